// ---- rtl/node_cfg_map.svh ----
// register numbers, field positions, reset values and counts of the node configuration block
`ifndef NODE_CFG_MAP_SVH
`define NODE_CFG_MAP_SVH
// ----------------------------------------------------------------
// register numbers
// ----------------------------------------------------------------
`define REG_NODE_ID 8'h05
`define REG_REF_DIV 8'h08
`define REG_SCAN_ID 8'h09
`define REG_USER_CODE 8'h0A
`define REG_DIR_LOW 8'h0C
`define REG_DIR_HIGH 8'h0D
`define REG_SPARE_A 8'h10
`define REG_SPARE_B 8'h11
`define REG_DEBUG_ORIGIN 8'h1F
`define REG_SYS_LINK_FIRST 8'h20
`define REG_SYS_LINK_LAST 8'h28
`define REG_PROC_LINK_FIRST 8'h40
`define REG_PROC_LINK_LAST 8'h47
// ----------------------------------------------------------------
// link table geometry
// ----------------------------------------------------------------
`define NUM_LINKS 17
`define PROC_IDX_BASE 8'h09
`define LINK_IDX_W 5
`define LINK_CFG_W 6
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define F_KIND_HI 25
`define F_KIND_LO 24
`define F_DEST_HI 23
`define F_DEST_LO 16
`define F_DIR_HI 11
`define F_DIR_LO 8
`define F_NET_HI 5
`define F_NET_LO 4
`define F_JUNK 2
`define F_DST_BUSY 1
`define F_SRC_BUSY 0
`define F_OTP_LO 18
`define F_DBG_SPARE 4
`define F_SPARE_HI 1
`define F_HALF_HI 15
`define NIBBLE_W 4
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define REF_DIV_RESET 16'h0003
`define ZERO_WORD 32'h0000_0000
`endif

// ---- rtl/node_cfg_pkg.sv ----
// types shared by the node configuration block
package node_cfg_pkg;
    typedef logic [7:0] regnum_t;
    typedef logic [31:0] word_t;
    typedef logic [15:0] node_id_t;
    typedef logic [3:0] dir_t;
    typedef logic [4:0] link_idx_t;
    typedef enum logic {CFG_IDLE, CFG_FETCH} cfg_state_e;
endpackage

// ---- rtl/link_state_mem.sv ----
// small register file holding direction and network of every link
`timescale 1ns/100ps
`include "node_cfg_map.svh"
module link_state_mem (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [`LINK_IDX_W-1:0] wr_addr,
    input wire logic [`LINK_CFG_W-1:0] wr_data,
    // read port
    input wire logic [`LINK_IDX_W-1:0] rd_addr,
    output logic [`LINK_CFG_W-1:0] rd_data
);
    logic [`LINK_CFG_W-1:0] mem_reg [`NUM_LINKS];

    // reset clears every entry so direction and network start at zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `NUM_LINKS; i++)
            begin
                mem_reg[i] <= '0;
            end
        end
        else if (wr_en && (int'(wr_addr) < `NUM_LINKS))
        begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else if (int'(rd_addr) < `NUM_LINKS)
        begin
            rd_data <= mem_reg[rd_addr];
        end
        else
        begin
            rd_data <= '0;
        end
    end
endmodule

// ---- rtl/switch_node_routing_config.sv ----
// configuration registers, link status and routing decision of a switch node
//
// Notes on behaviour
// - route each packet by its highest identifier bit differing from this node
// - low table: eight 4-bit directions for bits 7..0, dimension 0 lowest, reset zero
// - high table: eight writable 4-bit directions for bits 15..8, reset zero
// - writable 16-bit reference divider in bits 15:0, reset 3, upper bits reserved
// - user code readout: programmed code in 31:18, fixable id in 17:0
// - debug origin: bit 0 processor zero, bit 1 processor one, latest event
// - link status bits 25:24 report source target kind
// - bits 23:16 show destination link number while the link is in use
// - system link direction field bits 11:8, writable, reset zero
// - network number bits 5:4 writable on every link, reset zero
// - bit 2 set while the current packet is junk and discarded
// - bit 1 destination side in use, bit 0 source side in use
// - system link registers 0x20 to 0x28
// - processor link registers 0x40 to 0x47, no direction field
// - own node identifier writable in bits 15:0, reset zero
// - registers reached only by numbered configuration reads and writes
`timescale 1ns/100ps
`include "node_cfg_map.svh"
module switch_node_routing_config #(
    // identity value is arbitrary
    parameter logic [31:0] SCAN_ID_CODE = 32'h0000_1001
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration access
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire node_cfg_pkg::regnum_t cfg_regnum,
    input wire node_cfg_pkg::word_t cfg_wdata,
    output node_cfg_pkg::word_t cfg_rdata,
    output logic cfg_ack,
    // identity straps
    input wire logic [13:0] otp_user_code,
    input wire logic [17:0] metal_id_code,
    // debug events
    input wire logic debug_event,
    input wire logic debug_from_zero,
    input wire logic debug_from_one,
    // routing decision
    input wire logic route_req,
    input wire node_cfg_pkg::node_id_t route_dest,
    output logic route_valid,
    output node_cfg_pkg::dir_t route_dir,
    output logic route_local,
    // link status from the fabric
    input wire logic [`NUM_LINKS-1:0] link_src_busy,
    input wire logic [`NUM_LINKS-1:0] link_dst_busy,
    input wire logic [`NUM_LINKS-1:0] link_junk,
    input wire logic [`NUM_LINKS-1:0][1:0] link_src_kind,
    input wire logic [`NUM_LINKS-1:0][7:0] link_dest_num,
    // reference clock enable
    output logic ref_tick
);
    import node_cfg_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_proc(input regnum_t n);
        return (n >= `REG_PROC_LINK_FIRST) && (n <= `REG_PROC_LINK_LAST);
    endfunction

    function automatic logic link_hit(input regnum_t n);
        return is_proc(n) || ((n >= `REG_SYS_LINK_FIRST) && (n <= `REG_SYS_LINK_LAST));
    endfunction

    function automatic link_idx_t link_index(input regnum_t n);
        if (is_proc(n))
        begin
            return link_idx_t'(n - `REG_PROC_LINK_FIRST + `PROC_IDX_BASE);
        end
        return link_idx_t'(n - `REG_SYS_LINK_FIRST);
    endfunction

    function automatic dir_t top_mismatch(input node_id_t diff);
        dir_t r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            if (diff[i])
            begin
                r = dir_t'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cfg_state_e state_reg;
    regnum_t req_num_reg;
    logic req_wr_reg;
    link_idx_t req_idx_reg;
    node_id_t node_id_reg;
    logic [15:0] ref_div_reg;
    logic [15:0] ref_cnt_reg;
    word_t dir_low_reg;
    word_t dir_high_reg;
    logic [1:0] spare_a_reg;
    logic [1:0] spare_b_reg;
    logic [1:0] debug_origin_reg;
    logic debug_spare_reg;
    logic [31:0] strap_meta_reg;
    logic [31:0] user_code_reg;
    logic take;
    logic wr_take;
    logic mem_we;
    logic [`LINK_CFG_W-1:0] mem_wdata;
    logic [`LINK_CFG_W-1:0] mem_rdata;
    word_t rd_word;
    node_id_t diff;

    // only a request seen while idle is taken; others are ignored
    assign take = cfg_req && (state_reg == CFG_IDLE);
    assign wr_take = take && cfg_write;

    // ----------------------------------------------------------------
    // request sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= CFG_IDLE;
            req_num_reg <= '0;
            req_wr_reg <= 1'b0;
            req_idx_reg <= '0;
        end
        else
        begin
            case (state_reg)
                CFG_IDLE:
                begin
                    if (cfg_req)
                    begin
                        state_reg <= CFG_FETCH;
                        req_num_reg <= cfg_regnum;
                        req_wr_reg <= cfg_write;
                        req_idx_reg <= link_index(cfg_regnum);
                    end
                end
                CFG_FETCH:
                begin
                    state_reg <= CFG_IDLE;
                end
                default:
                begin
                    state_reg <= CFG_IDLE;
                end
            endcase
        end
    end

    // the link table answers one cycle late, so every access is answered two cycles on
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ack <= 1'b0;
            cfg_rdata <= `ZERO_WORD;
        end
        else
        begin
            cfg_ack <= (state_reg == CFG_FETCH);
            if (state_reg == CFG_FETCH)
            begin
                cfg_rdata <= req_wr_reg ? `ZERO_WORD : rd_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // plain registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            node_id_reg <= '0;
            ref_div_reg <= `REF_DIV_RESET;
            dir_low_reg <= `ZERO_WORD;
            dir_high_reg <= `ZERO_WORD;
            spare_a_reg <= '0;
            spare_b_reg <= '0;
        end
        else if (wr_take)
        begin
            case (cfg_regnum)
                `REG_NODE_ID: node_id_reg <= cfg_wdata[`F_HALF_HI:0];
                `REG_REF_DIV: ref_div_reg <= cfg_wdata[`F_HALF_HI:0];
                `REG_DIR_LOW: dir_low_reg <= cfg_wdata;
                `REG_DIR_HIGH: dir_high_reg <= cfg_wdata;
                `REG_SPARE_A: spare_a_reg <= cfg_wdata[`F_SPARE_HI:0];
                `REG_SPARE_B: spare_b_reg <= cfg_wdata[`F_SPARE_HI:0];
                default:
                begin
                end
            endcase
        end
    end

    // a debug event in the same cycle as a software write wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            debug_origin_reg <= '0;
            debug_spare_reg <= 1'b0;
        end
        else
        begin
            if (debug_event)
            begin
                debug_origin_reg <= {debug_from_one, debug_from_zero};
            end
            else if (wr_take && (cfg_regnum == `REG_DEBUG_ORIGIN))
            begin
                debug_origin_reg <= cfg_wdata[`F_DST_BUSY:0];
            end
            if (wr_take && (cfg_regnum == `REG_DEBUG_ORIGIN))
            begin
                debug_spare_reg <= cfg_wdata[`F_DBG_SPARE];
            end
        end
    end

    // straps come from outside this clock, so they pass two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_meta_reg <= `ZERO_WORD;
            user_code_reg <= `ZERO_WORD;
        end
        else
        begin
            strap_meta_reg <= {otp_user_code, metal_id_code};
            user_code_reg <= strap_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // reference clock divider
    // ----------------------------------------------------------------
    // one tick every divider+1 cycles; a new divider is compared from the cycle after the write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_cnt_reg <= '0;
            ref_tick <= 1'b0;
        end
        else if (ref_cnt_reg >= ref_div_reg)
        begin
            ref_cnt_reg <= '0;
            ref_tick <= 1'b1;
        end
        else
        begin
            ref_cnt_reg <= ref_cnt_reg + 16'h0001;
            ref_tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // link table
    // ----------------------------------------------------------------
    assign mem_we = wr_take && link_hit(cfg_regnum);
    // processor links have no direction, so a zero is stored there
    assign mem_wdata = {is_proc(cfg_regnum) ? 4'h0 : cfg_wdata[`F_DIR_HI:`F_DIR_LO],
                        cfg_wdata[`F_NET_HI:`F_NET_LO]};

    link_state_mem u_link_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(mem_we),
        .wr_addr(link_index(cfg_regnum)),
        .wr_data(mem_wdata),
        .rd_addr(link_index(cfg_regnum)),
        .rd_data(mem_rdata)
    );

    // ----------------------------------------------------------------
    // read composition
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_word = `ZERO_WORD;
        if (link_hit(req_num_reg))
        begin
            rd_word[`F_KIND_HI:`F_KIND_LO] = link_src_kind[req_idx_reg];
            if (link_src_busy[req_idx_reg] || link_dst_busy[req_idx_reg])
            begin
                rd_word[`F_DEST_HI:`F_DEST_LO] = link_dest_num[req_idx_reg];
            end
            if (!is_proc(req_num_reg))
            begin
                rd_word[`F_DIR_HI:`F_DIR_LO] = mem_rdata[`LINK_CFG_W-1:2];
            end
            rd_word[`F_NET_HI:`F_NET_LO] = mem_rdata[1:0];
            rd_word[`F_JUNK] = link_junk[req_idx_reg];
            rd_word[`F_DST_BUSY] = link_dst_busy[req_idx_reg];
            rd_word[`F_SRC_BUSY] = link_src_busy[req_idx_reg];
        end
        else
        begin
            case (req_num_reg)
                `REG_NODE_ID: rd_word[`F_HALF_HI:0] = node_id_reg;
                `REG_REF_DIV: rd_word[`F_HALF_HI:0] = ref_div_reg;
                `REG_SCAN_ID: rd_word = SCAN_ID_CODE;
                `REG_USER_CODE: rd_word = user_code_reg;
                `REG_DIR_LOW: rd_word = dir_low_reg;
                `REG_DIR_HIGH: rd_word = dir_high_reg;
                `REG_SPARE_A: rd_word[`F_SPARE_HI:0] = spare_a_reg;
                `REG_SPARE_B: rd_word[`F_SPARE_HI:0] = spare_b_reg;
                `REG_DEBUG_ORIGIN:
                begin
                    rd_word[`F_DBG_SPARE] = debug_spare_reg;
                    rd_word[`F_DST_BUSY:0] = debug_origin_reg;
                end
                default: rd_word = `ZERO_WORD;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // routing decision
    // ----------------------------------------------------------------
    assign diff = route_dest ^ node_id_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_valid <= 1'b0;
            route_dir <= '0;
            route_local <= 1'b0;
        end
        else
        begin
            route_valid <= route_req;
            if (route_req)
            begin
                route_local <= (diff == 16'h0000);
                route_dir <= dir_t'({dir_high_reg, dir_low_reg} >>
                             (`NIBBLE_W * top_mismatch(diff)));
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_route_top_bit: assert property ((route_req && (diff >> 15) == 16'h0001) |=>
        (route_valid && !route_local && route_dir == $past(dir_high_reg[31:28])))
        else $error("top mismatch did not pick dimension 15");
    a_route_low_bit: assert property ((route_req && diff == 16'h0001) |=>
        (route_dir == $past(dir_low_reg[3:0])))
        else $error("bit 0 mismatch did not pick dimension 0");
    a_route_local: assert property ((route_req && route_dest == node_id_reg) |=>
        route_local)
        else $error("own identifier not delivered locally");
    a_cfg_ack_delay: assert property (take |-> ##1 !cfg_ack ##1 cfg_ack)
        else $error("access not answered two cycles after request");
    a_cfg_ack_pulse: assert property (cfg_ack |=> !cfg_ack)
        else $error("answer held longer than one cycle");
    a_debug_latest: assert property (debug_event |=>
        debug_origin_reg == $past({debug_from_one, debug_from_zero}))
        else $error("debug origin not recorded");
    a_div_write: assert property ((wr_take && cfg_regnum == `REG_REF_DIV) |=>
        ref_div_reg == $past(cfg_wdata[15:0]))
        else $error("reference divider not written");
    a_tick_spacing: assert property ((ref_tick && ref_div_reg != 16'h0000) |=> !ref_tick)
        else $error("reference ticks back to back");
    a_proc_no_dir: assert property ((take && !cfg_write && is_proc(cfg_regnum)) |->
        ##2 (cfg_rdata[11:8] == 4'h0 && cfg_rdata[31:26] == 6'h00))
        else $error("processor link shows a direction");
    a_link_src_bit: assert property ((take && !cfg_write && cfg_regnum == 8'h20) |->
        ##2 (cfg_rdata[0] == $past(link_src_busy[0])))
        else $error("source busy bit wrong");
endmodule

// ---- dv/fabric_model.sv ----
// fabric side model: link status levels and processor debug events
`timescale 1ns/100ps
`include "node_cfg_map.svh"
module fabric_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bench asks for new traffic
    input wire logic shuffle,
    // link levels
    output logic [`NUM_LINKS-1:0] link_src_busy,
    output logic [`NUM_LINKS-1:0] link_dst_busy,
    output logic [`NUM_LINKS-1:0] link_junk,
    output logic [`NUM_LINKS-1:0][1:0] link_src_kind,
    output logic [`NUM_LINKS-1:0][7:0] link_dest_num,
    // debug events
    output logic debug_event,
    output logic debug_from_zero,
    output logic debug_from_one
);
    // levels move only on request, so a read in flight sees stable status
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_src_busy <= '0;
            link_dst_busy <= '0;
            link_junk <= '0;
            link_src_kind <= '0;
            link_dest_num <= '0;
            debug_event <= 1'b0;
            {debug_from_one, debug_from_zero} <= 2'h0;
        end
        else
        begin
            debug_event <= shuffle;
            if (shuffle)
            begin
                link_src_busy <= 17'($urandom);
                link_dst_busy <= 17'($urandom);
                link_junk <= 17'($urandom);
                link_src_kind <= 34'({$urandom, $urandom});
                for (int i = 0; i < `NUM_LINKS; i++)
                    link_dest_num[i] <= 8'($urandom);
                {debug_from_one, debug_from_zero} <= 2'($urandom_range(3, 1));
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the switch node configuration block
`timescale 1ns/100ps
`include "node_cfg_map.svh"
module tb_top;
    import node_cfg_pkg::*;
    // identity value is arbitrary
    localparam logic [31:0] SCAN = 32'h0000_5A17;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_req = 1'b0;
    logic cfg_write = 1'b0;
    regnum_t cfg_regnum = 8'h00;
    word_t cfg_wdata = 32'h0000_0000;
    word_t cfg_rdata;
    logic cfg_ack;
    logic [13:0] otp = 14'h0000;
    logic [17:0] metal = 18'h00000;
    logic route_req = 1'b0;
    node_id_t route_dest = 16'h0000;
    logic route_valid, route_local, ref_tick;
    dir_t route_dir;
    logic shuffle = 1'b0;
    logic [`NUM_LINKS-1:0] src_busy, dst_busy, junk;
    logic [`NUM_LINKS-1:0][1:0] kind;
    logic [`NUM_LINKS-1:0][7:0] dnum;
    logic dbg_ev, dbg_zero, dbg_one;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int link_dir[`NUM_LINKS];
    int link_net[`NUM_LINKS];
    word_t dir_lo = 0;
    word_t dir_hi = 0;
    node_id_t own_id = 0;

    always #10 mclk = ~mclk;

    switch_node_routing_config #(.SCAN_ID_CODE(SCAN)) dut (
        .mclk(mclk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_regnum(cfg_regnum), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .otp_user_code(otp), .metal_id_code(metal),
        .debug_event(dbg_ev), .debug_from_zero(dbg_zero), .debug_from_one(dbg_one),
        .route_req(route_req), .route_dest(route_dest), .route_valid(route_valid),
        .route_dir(route_dir), .route_local(route_local), .link_src_busy(src_busy),
        .link_dst_busy(dst_busy), .link_junk(junk), .link_src_kind(kind),
        .link_dest_num(dnum), .ref_tick(ref_tick));

    fabric_model far (
        .mclk(mclk), .rst_n(rst_n), .shuffle(shuffle), .link_src_busy(src_busy),
        .link_dst_busy(dst_busy), .link_junk(junk), .link_src_kind(kind),
        .link_dest_num(dnum), .debug_event(dbg_ev), .debug_from_zero(dbg_zero),
        .debug_from_one(dbg_one));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input word_t got, input word_t exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    task automatic cfg(input logic wr, input regnum_t r, input word_t d, output word_t q);
        int n;
        n = 0;
        cfg_req = 1'b1;
        cfg_write = wr;
        cfg_regnum = r;
        cfg_wdata = d;
        step();
        cfg_req = 1'b0;
        while (cfg_ack !== 1'b1 && n < 4)
        begin
            step();
            n++;
        end
        check(32'(n), 32'h1, "answer delay");
        q = cfg_rdata;
    endtask

    task automatic rd(input regnum_t r, input word_t e);
        word_t q;
        cfg(1'b0, r, 32'h0, q);
        check(q, e, $sformatf("read %h", r));
    endtask

    task automatic wr(input regnum_t r, input word_t d);
        word_t q;
        cfg(1'b1, r, d, q);
        check(q, 32'h0, "write answer");
    endtask

    task automatic tick_gap(output int p);
        p = 0;
        step();
        while (ref_tick !== 1'b1 && p < 40)
        begin
            step();
            p++;
        end
        p++;
    endtask

    function automatic regnum_t link_reg(input int i);
        return 8'(i < 9 ? 32'h20 + i : 32'h37 + i);
    endfunction

    // status as the fabric shows it, plus the shadowed writable fields
    function automatic word_t link_exp(input int i);
        word_t e;
        e = 32'h0;
        e[25:24] = kind[i];
        if (src_busy[i] || dst_busy[i])
            e[23:16] = dnum[i];
        if (i < 9)
            e[11:8] = 4'(link_dir[i]);
        e[5:4] = 2'(link_net[i]);
        e[2:0] = {junk[i], dst_busy[i], src_busy[i]};
        return e;
    endfunction

    function automatic int top_diff(input node_id_t a, input node_id_t b);
        top_diff = -1;
        for (int k = 0; k < 16; k++)
            if (a[k] != b[k])
                top_diff = k;
    endfunction

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("ERROR t=%0t run did not finish", $time);
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int p, k, b;
        logic [63:0] tbl;
        node_id_t d;
        word_t w;
        void'($urandom(56));
        otp = 14'($urandom);
        metal = 18'($urandom);
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        rd(`REG_REF_DIV, 32'h3);
        rd(`REG_DIR_LOW, 32'h0);
        rd(`REG_DIR_HIGH, 32'h0);
        rd(`REG_NODE_ID, 32'h0);
        rd(`REG_SCAN_ID, SCAN);
        rd(`REG_USER_CODE, {otp, metal});
        for (int i = 0; i < `NUM_LINKS; i++)
            rd(link_reg(i), link_exp(i));
        $display("test reset values done");

        dir_lo = $urandom;
        dir_hi = $urandom;
        own_id = 16'($urandom);
        w = 32'($urandom_range(9, 1));
        wr(`REG_REF_DIV, w | 32'hFFFF_0000);
        rd(`REG_REF_DIV, w);
        wr(`REG_DIR_LOW, dir_lo);
        rd(`REG_DIR_LOW, dir_lo);
        wr(`REG_DIR_HIGH, dir_hi);
        rd(`REG_DIR_HIGH, dir_hi);
        wr(`REG_NODE_ID, {16'hFFFF, own_id});
        rd(`REG_NODE_ID, {16'h0, own_id});
        wr(`REG_SCAN_ID, ~SCAN);
        rd(`REG_SCAN_ID, SCAN);
        wr(`REG_SPARE_A, 32'hFFFF_FFFF);
        rd(`REG_SPARE_A, 32'h3);
        wr(8'h29, 32'hFFFF_FFFF);
        foreach (tbl[j])
            if (j < 4)
                rd(8'({8'h0B, 8'h29, 8'h48, 8'h3F} >> (8 * j)), 32'h0);
        // a request held into the fetch cycle must be ignored
        cfg_req = 1'b1;
        cfg_write = 1'b1;
        cfg_regnum = `REG_SPARE_B;
        cfg_wdata = 32'h0000_0002;
        step();
        cfg_regnum = `REG_SPARE_A;
        cfg_wdata = 32'h0000_0000;
        step();
        check(32'(cfg_ack), 32'h1, "first ack of held request");
        cfg_req = 1'b0;
        step();
        check(32'(cfg_ack), 32'h0, "refused request answered");
        rd(`REG_SPARE_A, 32'h3);
        rd(`REG_SPARE_B, 32'h2);
        $display("test register access done");

        tick_gap(p);
        tick_gap(p);
        check(32'(p), w + 1, "tick period");
        wr(`REG_REF_DIV, 32'h0);
        tick_gap(p);
        tick_gap(p);
        check(32'(p), 32'h1, "tick period");
        $display("test reference tick done");

        // back-to-back routing requests, every dimension and the local case
        tbl = {dir_hi, dir_lo};
        for (int i = 0; i < 48; i++)
        begin
            b = i % 17;
            d = (b == 16) ? own_id : own_id ^ ((16'h1 << b) | (16'($urandom) & ((16'h1 << b) - 1)));
            route_req = 1'b1;
            route_dest = d;
            step();
            k = top_diff(d, own_id);
            check(32'(route_valid), 32'h1, "route valid");
            check(32'(route_local), 32'(k < 0), "route local");
            if (k >= 0)
                check(32'(route_dir), 32'(tbl[4 * k +: 4]), "route dir");
        end
        route_req = 1'b0;
        step();
        check(32'(route_valid), 32'h0, "route idle");
        $display("test routing done");

        for (int r = 0; r < 3; r++)
        begin
            wr(`REG_DEBUG_ORIGIN, 32'h13);
            rd(`REG_DEBUG_ORIGIN, 32'h13);
            shuffle = 1'b1;
            step();
            shuffle = 1'b0;
            step();
            rd(`REG_DEBUG_ORIGIN, {30'h4, dbg_one, dbg_zero});
            for (int i = 0; i < `NUM_LINKS; i++)
            begin
                w = $urandom;
                wr(link_reg(i), w);
                if (i < 9)
                    link_dir[i] = w[11:8];
                link_net[i] = w[5:4];
                rd(link_reg(i), link_exp(i));
            end
        end
        $display("test link status and debug done");

        // reset again in mid-run; registers must return to their reset values
        rst_n = 1'b0;
        step();
        rst_n = 1'b1;
        rd(`REG_REF_DIV, 32'h3);
        rd(`REG_DIR_HIGH, 32'h0);
        rd(`REG_NODE_ID, 32'h0);
        rd(`REG_DEBUG_ORIGIN, 32'h0);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
